/* File: design/ofsr_byte_guard.sv */
// one output byte: forced-off protection and per-bit ground fault flags
module ofsr_byte_guard
    import ofsr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] drive_req,
    input wire logic overload_sync,
    input wire logic [7:0] ground_fault_sync,
    output logic [7:0] drive_out,
    output logic forced_off,
    output logic [7:0] fault_flags
);
    logic next_forced_off;
    logic [7:0] next_drive_out;
    logic [7:0] next_fault_flags;

    always_comb begin
        // whole byte is held off only while the overload cause persists
        next_forced_off = overload_sync;
        next_drive_out = overload_sync ? 8'h00 : drive_req;
        // flags follow detection, so they drop as soon as a bit is healthy again
        next_fault_flags = ground_fault_sync;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            forced_off <= 1'b0;
            drive_out <= 8'h00;
            fault_flags <= 8'h00;
        end else begin
            forced_off <= next_forced_off;
            drive_out <= next_drive_out;
            fault_flags <= next_fault_flags;
        end
    end
endmodule

/* File: design/ofsr_pkg.sv */
// package: register map, field layout and fixed sizes of the output fault status reporter
package ofsr_pkg;
    localparam int OFSR_OUT_BYTES = 8;
    localparam int OFSR_IN_BYTES = 12;
    localparam int OFSR_MPG_COUNT = 3;
    localparam logic [7:0] OFSR_ADDR_W = 8'h08;
    // register byte addresses
    localparam logic [7:0] OFSR_REG_OUT_DATA_LO = 8'h00;
    localparam logic [7:0] OFSR_REG_OUT_DATA_HI = 8'h04;
    localparam logic [7:0] OFSR_REG_BASE = 8'h08;
    localparam logic [7:0] OFSR_REG_CONFIG = 8'h0C;
    localparam logic [7:0] OFSR_REG_FORCED = 8'h10;
    localparam logic [7:0] OFSR_REG_PENDING = 8'h14;
    localparam logic [7:0] OFSR_REG_RECORD = 8'h18;
    localparam logic [7:0] OFSR_REG_FLAGS0 = 8'h20;
    // base register fields
    localparam int OFSR_BASE_IN_LSB = 0;
    localparam int OFSR_BASE_OUT_LSB = 16;
    // config register fields
    localparam int OFSR_CFG_GROUP_LSB = 0;
    localparam int OFSR_CFG_PATH_LSB = 8;
    localparam int OFSR_CFG_SLOT_LSB = 16;
    localparam int OFSR_CFG_MPG_EN_BIT = 24;
    // record register fields
    localparam int OFSR_REC_DATA_LSB = 0;
    localparam int OFSR_REC_INFO_LSB = 8;
    localparam int OFSR_REC_SLOT_LSB = 16;
    localparam int OFSR_REC_PATH_LSB = 24;
    localparam int OFSR_REC_VALID_BIT = 31;
    // reset values and response codes
    localparam logic [31:0] OFSR_BASE_RESET = 32'h0000_0000;
    localparam logic [31:0] OFSR_CONFIG_RESET = 32'h0001_0000;
    localparam logic [1:0] OFSR_RESP_OKAY = 2'h0;
    localparam logic [1:0] OFSR_RESP_SLVERR = 2'h2;
endpackage

/* File: design/ofsr_record_scan.sv */
// walks the byte offsets and emits one status alarm record per faulty byte
module ofsr_record_scan
    import ofsr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [63:0] flags_all,
    output logic [2:0] rec_info,
    output logic [7:0] rec_data,
    output logic rec_valid
);
    logic [2:0] idx;
    logic [2:0] next_idx;
    logic [2:0] next_rec_info;
    logic [7:0] next_rec_data;
    logic next_rec_valid;
    logic [7:0] cur;

    always_comb begin
        cur = flags_all[idx*8 +: 8];
        next_idx = idx + 3'h1;
        // a record names the byte by its offset within the slot
        next_rec_info = idx;
        next_rec_data = cur;
        next_rec_valid = (cur != 8'h00);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idx <= 3'h0;
            rec_info <= 3'h0;
            rec_data <= 8'h00;
            rec_valid <= 1'b0;
        end else begin
            idx <= next_idx;
            rec_info <= next_rec_info;
            rec_data <= next_rec_data;
            rec_valid <= next_rec_valid;
        end
    end
endmodule

/* File: design/ofsr_top.sv */
// output fault status reporter: protected output bytes, fault records, AXI4-Lite registers
// Operation
// - three pulse generators are addressed only together through their own slot
// - overcurrent or overtemperature holds all eight bits of that byte off
// - a driver fault never stops the module; fault location is reported instead
// - ground faults are detected per output bit and reported as status alarms
// - record ports carry group number, controller path, slot and alarm information number; the record register drops the group and keeps path bits 6:0
// - alarm information number is the faulty byte's offset, zero through seven
// - alarm data bit k set means ground fault on output bit k
module ofsr_top
    import ofsr_pkg::*;
#(
    parameter int NUM_BYTES = OFSR_OUT_BYTES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_BYTES-1:0] driver_overload,
    input wire logic [NUM_BYTES*8-1:0] driver_ground_fault,
    output logic [NUM_BYTES*8-1:0] output_drive,
    output logic pulse_gen_enable,
    output logic record_valid,
    output logic [7:0] record_group,
    output logic [7:0] record_path,
    output logic [7:0] record_slot,
    output logic [2:0] record_info,
    output logic [7:0] record_data
);
    // pin inputs pass two flip-flops before any logic looks at them
    logic [NUM_BYTES-1:0] ovl_meta;
    logic [NUM_BYTES-1:0] ovl_sync;
    logic [NUM_BYTES*8-1:0] gnd_meta;
    logic [NUM_BYTES*8-1:0] gnd_sync;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovl_meta <= '0;
            ovl_sync <= '0;
            gnd_meta <= '0;
            gnd_sync <= '0;
        end else begin
            ovl_meta <= driver_overload;
            ovl_sync <= ovl_meta;
            gnd_meta <= driver_ground_fault;
            gnd_sync <= gnd_meta;
        end
    end

    // software-visible state
    logic [63:0] out_data;
    logic [31:0] base_reg;
    logic [31:0] cfg_reg;
    logic [NUM_BYTES-1:0] forced;
    logic [NUM_BYTES*8-1:0] flags;

    genvar g;
    generate
        for (g = 0; g < NUM_BYTES; g++) begin : gen_byte
            ofsr_byte_guard u_guard (
                .aclk(aclk),
                .aresetn(aresetn),
                .drive_req(out_data[g*8 +: 8]),
                .overload_sync(ovl_sync[g]),
                .ground_fault_sync(gnd_sync[g*8 +: 8]),
                .drive_out(output_drive[g*8 +: 8]),
                .forced_off(forced[g]),
                .fault_flags(flags[g*8 +: 8])
            );
        end
    endgenerate

    // scanner always sees eight bytes so offsets stay 0..7
    logic [63:0] flags_all;
    logic [2:0] scan_info;
    logic [7:0] scan_data;
    logic scan_valid;

    always_comb begin
        flags_all = '0;
        flags_all[NUM_BYTES*8-1:0] = flags;
    end

    ofsr_record_scan u_scan (
        .aclk(aclk),
        .aresetn(aresetn),
        .flags_all(flags_all),
        .rec_info(scan_info),
        .rec_data(scan_data),
        .rec_valid(scan_valid)
    );

    // record output: identity fields come from configuration
    logic next_record_valid;
    logic [7:0] next_record_group;
    logic [7:0] next_record_path;
    logic [7:0] next_record_slot;
    logic [2:0] next_record_info;
    logic [7:0] next_record_data;
    logic next_pulse_gen_enable;

    always_comb begin
        next_record_valid = scan_valid;
        next_record_group = cfg_reg[OFSR_CFG_GROUP_LSB +: 8];
        next_record_path = cfg_reg[OFSR_CFG_PATH_LSB +: 8];
        next_record_slot = cfg_reg[OFSR_CFG_SLOT_LSB +: 8];
        next_record_info = scan_info;
        next_record_data = scan_data;
        // one enable for all generators: no per-generator control exists
        next_pulse_gen_enable = cfg_reg[OFSR_CFG_MPG_EN_BIT];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            record_valid <= 1'b0;
            record_group <= 8'h00;
            record_path <= 8'h00;
            record_slot <= 8'h00;
            record_info <= 3'h0;
            record_data <= 8'h00;
            pulse_gen_enable <= 1'b0;
        end else begin
            record_valid <= next_record_valid;
            record_group <= next_record_group;
            record_path <= next_record_path;
            record_slot <= next_record_slot;
            record_info <= next_record_info;
            record_data <= next_record_data;
            pulse_gen_enable <= next_pulse_gen_enable;
        end
    end

    // AXI4-Lite write: address and data accepted in either order, response after both
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic [63:0] next_out_data;
    logic [31:0] next_base_reg;
    logic [31:0] next_cfg_reg;
    logic do_write;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_out_data = out_data;
        next_base_reg = base_reg;
        next_cfg_reg = cfg_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        do_write = aw_held && w_held && !s_axi_bvalid;
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = OFSR_RESP_OKAY;
            case ({aw_addr[7:2], 2'b00})
                OFSR_REG_OUT_DATA_LO: next_out_data[31:0] = merge(out_data[31:0], w_data, w_strb);
                OFSR_REG_OUT_DATA_HI: next_out_data[63:32] = merge(out_data[63:32], w_data, w_strb);
                OFSR_REG_BASE: next_base_reg = merge(base_reg, w_data, w_strb);
                OFSR_REG_CONFIG: next_cfg_reg = merge(cfg_reg, w_data, w_strb);
                default: next_bresp = OFSR_RESP_SLVERR;
            endcase
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= OFSR_RESP_OKAY;
            out_data <= 64'h0000_0000_0000_0000;
            base_reg <= OFSR_BASE_RESET;
            cfg_reg <= OFSR_CONFIG_RESET;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            out_data <= next_out_data;
            base_reg <= next_base_reg;
            cfg_reg <= next_cfg_reg;
            // ready drops for the cycle after a take so no second item slips in
            s_axi_awready <= !next_aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !next_w_held && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // AXI4-Lite read
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [31:0] rd_word;
    logic rd_ok;
    logic [3:0] rd_byte;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        rd_byte = 4'h0;
        case ({s_axi_araddr[7:2], 2'b00})
            OFSR_REG_OUT_DATA_LO: rd_word = out_data[31:0];
            OFSR_REG_OUT_DATA_HI: rd_word = out_data[63:32];
            OFSR_REG_BASE: rd_word = base_reg;
            OFSR_REG_CONFIG: rd_word = cfg_reg;
            OFSR_REG_FORCED: rd_word[NUM_BYTES-1:0] = forced;
            OFSR_REG_PENDING: begin
                for (int i = 0; i < NUM_BYTES; i++) begin
                    rd_word[i] = (flags[i*8 +: 8] != 8'h00);
                end
            end
            OFSR_REG_RECORD: begin
                rd_word[OFSR_REC_DATA_LSB +: 8] = record_data;
                rd_word[OFSR_REC_INFO_LSB +: 3] = record_info;
                rd_word[OFSR_REC_SLOT_LSB +: 8] = record_slot;
                rd_word[OFSR_REC_PATH_LSB +: 7] = record_path[6:0];
                rd_word[OFSR_REC_VALID_BIT] = record_valid;
            end
            default: begin
                rd_byte = s_axi_araddr[5:2] - 4'h8;
                if (s_axi_araddr >= OFSR_REG_FLAGS0 && rd_byte < 4'(NUM_BYTES)) begin
                    rd_word[7:0] = flags[rd_byte[2:0]*8 +: 8];
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rdata = rd_word;
            next_rresp = rd_ok ? OFSR_RESP_OKAY : OFSR_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end else if (!s_axi_rvalid) begin
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= OFSR_RESP_OKAY;
        end else begin
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end
endmodule

/* File: tb/ofsr_ctrl_model.sv */
// ladder-side model: gathers the status alarm records of each output byte
module ofsr_ctrl_model (
    input wire logic aclk,
    input wire logic clr,
    input wire logic record_valid,
    input wire logic [2:0] record_info,
    input wire logic [7:0] record_data,
    input wire logic [7:0] record_slot,
    output logic [63:0] rec_bytes,
    output logic [7:0] rec_seen,
    output logic [7:0] rec_slot
);
    timeunit 1ns;
    timeprecision 1ps;
    // eight byte places: the output block is eight bytes in one slot
    // pulse generator data never reaches this side
    always @(posedge aclk) begin
        if (clr) begin
            rec_bytes <= '0;
            rec_seen <= '0;
        end else if (record_valid) begin
            rec_bytes[record_info*8 +: 8] <= record_data;
            rec_seen[record_info] <= 1'b1;
            rec_slot <= record_slot;
        end
    end
endmodule

/* File: tb/ofsr_top_chk.sv */
// checker bound to ofsr_top: bus timing, forced-off bytes and alarm records
module ofsr_top_chk
    import ofsr_pkg::*;
#(
    parameter int NUM_BYTES = OFSR_OUT_BYTES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NUM_BYTES-1:0] driver_overload,
    input wire logic [NUM_BYTES*8-1:0] driver_ground_fault,
    input wire logic [NUM_BYTES*8-1:0] output_drive,
    input wire logic record_valid,
    input wire logic [2:0] record_info,
    input wire logic [7:0] record_data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // cycles the fault pins have held still; records lag the pins by a few edges
    logic [4:0] stab;
    always_ff @(posedge aclk) begin
        if (!aresetn || driver_ground_fault != $past(driver_ground_fault))
            stab <= 5'h00;
        else if (stab != 5'h1F)
            stab <= stab + 5'h01;
    end
    function automatic logic [NUM_BYTES*8-1:0] spread(input logic [NUM_BYTES-1:0] m);
        for (int i = 0; i < NUM_BYTES; i++)
            spread[i*8 +: 8] = {8{m[i]}};
    endfunction
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_settled;
        stab >= 5'h0C;
    endsequence
    property p_wr_lat;
        s_wr_take |-> ##2 s_axi_bvalid;
    endproperty
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_force;
        (output_drive & spread($past(driver_overload, 3) & $past(driver_overload, 4))) == '0;
    endproperty
    property p_rec_nz;
        record_valid |-> record_data != 8'h00;
    endproperty
    property p_rec_data;
        s_settled ##0 record_valid |-> record_data == driver_ground_fault[record_info*8 +: 8];
    endproperty
    property p_rec_every;
        stab == 5'h10 && driver_ground_fault != '0 |-> ##[0:9] record_valid;
    endproperty
    property p_rec_quiet;
        s_settled ##0 driver_ground_fault == '0 |-> !record_valid;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write response late");
    a_rd_lat: assert property (p_rd_lat) else $error("read data late");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    a_force: assert property (p_force) else $error("overloaded byte still driven");
    a_rec_nz: assert property (p_rec_nz) else $error("record without fault bits");
    a_rec_data: assert property (p_rec_data) else $error("record byte mismatch");
    a_rec_every: assert property (p_rec_every) else $error("faulty byte not reported");
    a_rec_quiet: assert property (p_rec_quiet) else $error("record after fault cleared");
endmodule

bind ofsr_top ofsr_top_chk #(.NUM_BYTES(NUM_BYTES)) u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .driver_overload, .driver_ground_fault, .output_drive,
    .record_valid, .record_info, .record_data);

/* File: tb/tb_top.sv */
// self-checking bench for the output fault status reporter
module tb_top
    import ofsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pulse_gen_enable, record_valid, clr;
    logic [7:0] s_axi_awaddr, s_axi_araddr, driver_overload, record_group, record_path, record_slot;
    logic [7:0] record_data, rec_seen, rec_slot;
    logic [31:0] s_axi_wdata, s_axi_rdata, cfg, d;
    logic [3:0] s_axi_wstrb;
    logic [2:0] s_axi_awprot, s_axi_arprot, record_info;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [63:0] driver_ground_fault, output_drive, rec_bytes, dat, gf, m;
    int err_count = 0, n_checks = 0, cyc = 0;
    ofsr_top #(.NUM_BYTES(8)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .driver_overload, .driver_ground_fault, .output_drive, .pulse_gen_enable, .record_valid,
        .record_group, .record_path, .record_slot, .record_info, .record_data);
    ofsr_ctrl_model u_ctrl (.aclk, .clr, .record_valid, .record_info, .record_data, .record_slot, .rec_bytes,
        .rec_seen, .rec_slot);
    initial forever #5 aclk = ~aclk;
    function automatic logic [63:0] spread(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
            spread[i*8 +: 8] = {8{v[i]}};
    endfunction
    function automatic logic [7:0] nz(input logic [63:0] v);
        for (int i = 0; i < 8; i++)
            nz[i] = |v[i*8 +: 8];
    endfunction
    task automatic chk_val(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        bit ad, wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && s_axi_awready) begin
                ad = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!wd && s_axi_wready) begin
                wd = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
        {driver_overload, driver_ground_fault} = '0;
        s_axi_wstrb = 4'hF;
        clr = 1'b1;
        void'($urandom(32'h7823447A));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFSR_REG_CONFIG, d, r);
        chk_val("config reset", OFSR_CONFIG_RESET, d);
        rd(8'h40, d, r);
        chk_resp("unmapped read", OFSR_RESP_SLVERR, r);
        wr(OFSR_REG_FLAGS0, 32'h0000_00FF, r);
        chk_resp("flags write", OFSR_RESP_SLVERR, r);
        // lanes 0 and 2 take the second word, lanes 1 and 3 keep the first
        d = $urandom;
        wr(OFSR_REG_BASE, d, r);
        s_axi_wstrb <= 4'h5;
        wr(OFSR_REG_BASE, ~d, r);
        s_axi_wstrb <= 4'hF;
        rd(OFSR_REG_BASE, cfg, r);
        chk_val("base merge", 64'((d & 32'hFF00_FF00) | (~d & 32'h00FF_00FF)), 64'(cfg));
        $display("test reset done");
        // one enable bit starts all pulse generators together
        cfg = {7'h00, 1'b1, 8'($urandom), 8'h00, 8'($urandom)} | (32'($urandom) & 32'h0000_FF00);
        wr(OFSR_REG_CONFIG, cfg, r);
        chk_resp("config write", OFSR_RESP_OKAY, r);
        // the enable is registered once more after the config word lands
        repeat (2) @(posedge aclk);
        chk_val("pulse enable", 64'h1, 64'(pulse_gen_enable));
        dat = {$urandom, $urandom};
        wr(OFSR_REG_OUT_DATA_LO, dat[31:0], r);
        wr(OFSR_REG_OUT_DATA_HI, dat[63:32], r);
        repeat (6) @(posedge aclk);
        chk_val("drive", dat, output_drive);
        $display("test config done");
        for (int i = 0; i < 9; i++) begin
            m = (i < 8) ? 64'(8'h01 << i) : 64'($urandom & 32'h0000_00FF);
            driver_overload <= m[7:0];
            repeat (6) @(posedge aclk);
            chk_val("forced drive", dat & ~spread(m[7:0]), output_drive);
            rd(OFSR_REG_FORCED, d, r);
            chk_val("forced bytes", m, 64'(d[7:0]));
            driver_overload <= 8'h00;
            repeat (6) @(posedge aclk);
            chk_val("released drive", dat, output_drive);
        end
        $display("test overload done");
        gf = {$urandom, $urandom};
        for (int k = 1; k < 7; k++)
            if ($urandom % 2)
                gf[k*8 +: 8] = 8'h00;
        gf[7:0] = 8'h01;
        gf[63:56] = 8'h80;
        for (int p = 0; p < 2; p++) begin
            driver_ground_fault <= gf;
            repeat (14) @(posedge aclk);
            clr <= 1'b0;
            repeat (10) @(posedge aclk);
            chk_val("record bytes", gf, rec_bytes);
            chk_val("record seen", 64'(nz(gf)), 64'(rec_seen));
            clr <= 1'b1;
            gf = '0;
        end
        chk_val("record slot", 64'(cfg[23:16]), 64'(rec_slot));
        chk_val("record group path", 64'(cfg[15:0]), 64'({record_path, record_group}));
        gf = {$urandom, $urandom};
        driver_ground_fault <= gf;
        repeat (8) @(posedge aclk);
        for (int k = 0; k < 8; k++) begin
            rd(OFSR_REG_FLAGS0 + 8'(4 * k), d, r);
            chk_val("flags reg", 64'(gf[k*8 +: 8]), 64'(d));
            chk_resp("flags resp", OFSR_RESP_OKAY, r);
        end
        rd(OFSR_REG_PENDING, d, r);
        chk_val("pending", 64'(nz(gf)), 64'(d));
        rd(OFSR_REG_RECORD, d, r);
        chk_val("record reg ident", 64'({cfg[14:8], cfg[23:16]}), 64'({d[30:24], d[23:16]}));
        chk_val("record reg data", 64'(gf[d[10:8]*8 +: 8] & {8{d[31]}}), 64'(d[7:0]));
        $display("test ground fault done");
        complete_run();
    end
endmodule
